/* File: rtl/gpdm_map.vh */
`ifndef GPDM_MAP_VH
`define GPDM_MAP_VH

// Register offsets
`define GPDM_REG_PIN2      8'h19
`define GPDM_REG_DMIC      8'h6b
`define GPDM_REG_PIN1      8'h70
`define GPDM_REG_LEVEL     8'h71
`define GPDM_REG_MASK      8'h72
`define GPDM_REG_STAT      8'h73

// Reset value of every control register
`define GPDM_RST_BYTE      8'h00

// Register fields: pin configuration, microphone, mask and level
`define GPDM_FN_MSB        3
`define GPDM_FN_LSB        0
`define GPDM_SRC1_MSB      5
`define GPDM_SRC1_LSB      4
`define GPDM_SRC2_MSB      7
`define GPDM_SRC2_LSB      6
`define GPDM_OSR_MSB       5
`define GPDM_OSR_LSB       4
`define GPDM_EDGE_MSB      5
`define GPDM_EDGE_LSB      4
`define GPDM_EN_MSB        3
`define GPDM_EN_LSB        0
`define GPDM_TRAIN1_BIT    4
`define GPDM_TRAIN2_BIT    5
`define GPDM_OUT1_BIT      0
`define GPDM_OUT2_BIT      1

// Pin function codes
`define GPDM_FN_IN         4'h0
`define GPDM_FN_OUT        4'h1
`define GPDM_FN_CLK        4'h2
`define GPDM_FN_IRQ        4'h3
`define GPDM_FN_IRQ_OR     4'h4

// Oversampling ratio codes
`define GPDM_OSR_128       2'h0
`define GPDM_OSR_64        2'h1
`define GPDM_OSR_32        2'h2

// Capture edge codes
`define GPDM_EDGE_RISE_BIT 0
`define GPDM_EDGE_FALL_BIT 1

// Timing
`define GPDM_CLK_HZ        100000000
`define GPDM_CLK_NS        10
`define GPDM_PULSE_NS      1000
`define GPDM_TRAIN_NS      10000
`define GPDM_REC_FS_HZ     48000

`endif

/* File: rtl/gpdm_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser; stage one feeds stage two only
module gpdm_sync #(
  parameter W = 1
) (
  input  wire         mclk_in,
  input  wire         nrst_in,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // Double flop against metastability
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule

/* File: rtl/gpdm_pulse.v */
`timescale 1ns/1ps
// Interrupt indication: one pulse per cause, or a train while the cause stands
module gpdm_pulse #(
  parameter WIDTH_CYC  = 100,
  parameter PERIOD_CYC = 1000,
  parameter CW         = 11
) (
  input  wire mclk_in,
  input  wire nrst_in,
  input  wire cause_in,
  input  wire train_in,
  output wire pulse_out
);
  // Counts are cut to the counter width on purpose; CW must cover PERIOD_CYC
  localparam [31:0]   LAST_W_I = WIDTH_CYC - 1;
  localparam [31:0]   LAST_P_I = PERIOD_CYC - 1;
  localparam [31:0]   WID_I    = WIDTH_CYC;
  localparam [CW-1:0] LAST_W   = LAST_W_I[CW-1:0];
  localparam [CW-1:0] LAST_P   = LAST_P_I[CW-1:0];
  localparam [CW-1:0] WID      = WID_I[CW-1:0];

  reg          cause_d_r;
  reg          active_r;
  reg [CW-1:0] cnt_r;
  reg          pulse_r;
  wire         start;

  assign start = cause_in & ~cause_d_r;

  // Pulse sequencer; a train restarts each period until the cause is cleared
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cause_d_r <= 1'b0;
      active_r  <= 1'b0;
      cnt_r     <= {CW{1'b0}};
      pulse_r   <= 1'b0;
    end else begin
      cause_d_r <= cause_in;
      if (start) begin
        active_r <= 1'b1;
        cnt_r    <= {CW{1'b0}};
        pulse_r  <= 1'b1;
      end else if (active_r) begin
        if (!train_in && cnt_r == LAST_W) begin
          active_r <= 1'b0;
          pulse_r  <= 1'b0;
        end else if (train_in && cnt_r == LAST_P) begin
          active_r <= cause_in;
          cnt_r    <= {CW{1'b0}};
          pulse_r  <= cause_in;
        end else begin
          cnt_r   <= cnt_r + 1'b1;
          pulse_r <= (cnt_r + 1'b1) < WID;
        end
      end else begin
        pulse_r <= 1'b0;
      end
    end
  end

  assign pulse_out = pulse_r;
endmodule

/* File: rtl/gpdm_top.v */
// Notes on behaviour
// - Exactly two pins, function set by registers
// - Input pin level readable by register read
// - Output pin drives programmed high or low
// - Pin may output internal clock or interrupt
// - Events: jack, button, short, gain-loop noise
// - Route one source, or OR of enabled
// - Status register shows which sources fired
// - Single pulse or train until status read
// - Microphone bits stream into decimation filter
// - Oversampling 128, 64 or 32 times rate
// - Mic mode: pin one clock, two data
// - Capture rising, falling or both edges
// - Left sample taken on rising edge
// - Right sample taken on falling edge
// - Mic mode disables analog recording conversion
`timescale 1ns/1ps
`include "gpdm_map.vh"
module gpdm_top #(
  parameter REC_FS_HZ = `GPDM_REC_FS_HZ
) (
  input  wire       mclk_in,
  input  wire       nrst_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output wire [7:0] reg_rdata_out,
  output wire       reg_rvalid_out,
  input  wire       evt_jack_in,
  input  wire       evt_button_in,
  input  wire       evt_short_in,
  input  wire       evt_auto_gain_loop_in,
  input  wire       general_pin_one_in,
  output wire       general_pin_one_out,
  output wire       general_pin_one_oe_n_out,
  input  wire       general_pin_two_in,
  output wire       general_pin_two_out,
  output wire       general_pin_two_oe_n_out,
  output wire       dmic_left_bit_out,
  output wire       dmic_left_valid_out,
  output wire       dmic_right_bit_out,
  output wire       dmic_right_valid_out,
  output wire       adc_analog_off_out
);

  //////////////////////////////////////////////////////////////////////////
  // Timing constants

  localparam PULSE_CYC_I = `GPDM_PULSE_NS / `GPDM_CLK_NS;
  localparam TRAIN_CYC_I = `GPDM_TRAIN_NS / `GPDM_CLK_NS;
  localparam PULSE_CYC   = (PULSE_CYC_I < 1) ? 1 : PULSE_CYC_I;
  localparam TRAIN_CYC   = (TRAIN_CYC_I <= PULSE_CYC) ? PULSE_CYC + 1 : TRAIN_CYC_I;
  // Phase step per cycle for two clock toggles per microphone bit
  localparam [63:0] STEP_128 =
    (64'd256 * REC_FS_HZ * 64'h0000_0001_0000_0000) / `GPDM_CLK_HZ;
  localparam [31:0] STEP_128_W = STEP_128[31:0];
  localparam [31:0] STEP_64_W  = STEP_128[32:1];
  localparam [31:0] STEP_32_W  = STEP_128[33:2];

  //////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0] pin1_cfg_r;
  reg  [7:0] pin2_cfg_r;
  reg  [7:0] dmic_cfg_r;
  reg  [7:0] level_r;
  reg  [7:0] mask_r;
  reg  [3:0] stat_r;
  reg  [3:0] stat_nxt;
  reg  [7:0] rdata_r;
  reg        rvalid_r;
  reg  [7:0] rdata_nxt;
  wire [1:0] pin_sync;
  wire [3:0] fn1;
  wire [3:0] fn2;
  wire [1:0] osr;
  wire [1:0] edge_sel;
  wire       mic_en;
  wire [3:0] events;
  wire       rd_stat;

  assign fn1      = pin1_cfg_r[`GPDM_FN_MSB:`GPDM_FN_LSB];
  assign fn2      = pin2_cfg_r[`GPDM_FN_MSB:`GPDM_FN_LSB];
  assign osr      = pin2_cfg_r[`GPDM_OSR_MSB:`GPDM_OSR_LSB];
  assign edge_sel = dmic_cfg_r[`GPDM_EDGE_MSB:`GPDM_EDGE_LSB];
  assign mic_en   = |edge_sel;
  assign events   = {evt_auto_gain_loop_in, evt_short_in, evt_button_in, evt_jack_in};
  assign rd_stat  = reg_rd_in && (reg_addr_in == `GPDM_REG_STAT);

  gpdm_sync #(
    .W (2)
  ) u_pin_sync (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .d_in    ({general_pin_two_in, general_pin_one_in}),
    .q_out   (pin_sync)
  );

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin1_cfg_r <= `GPDM_RST_BYTE;
      pin2_cfg_r <= `GPDM_RST_BYTE;
      dmic_cfg_r <= `GPDM_RST_BYTE;
      level_r    <= `GPDM_RST_BYTE;
      mask_r     <= `GPDM_RST_BYTE;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `GPDM_REG_PIN1:  pin1_cfg_r <= reg_wdata_in;
        `GPDM_REG_PIN2:  pin2_cfg_r <= reg_wdata_in;
        `GPDM_REG_DMIC:  dmic_cfg_r <= reg_wdata_in;
        `GPDM_REG_LEVEL: level_r    <= reg_wdata_in;
        `GPDM_REG_MASK:  mask_r     <= reg_wdata_in;
        default:         level_r    <= level_r;
      endcase
    end
  end

  // read clears reported bits, a new event in that cycle wins
  always @* begin
    stat_nxt = stat_r;
    if (rd_stat) begin
      stat_nxt = 4'h0;
    end
    stat_nxt = stat_nxt | events;
  end

  // input levels visible through the level register
  always @* begin
    case (reg_addr_in)
      `GPDM_REG_PIN1:  rdata_nxt = pin1_cfg_r;
      `GPDM_REG_PIN2:  rdata_nxt = pin2_cfg_r;
      `GPDM_REG_DMIC:  rdata_nxt = dmic_cfg_r;
      `GPDM_REG_LEVEL: rdata_nxt = {2'h0, pin_sync, 2'h0, level_r[1:0]};
      `GPDM_REG_MASK:  rdata_nxt = mask_r;
      `GPDM_REG_STAT:  rdata_nxt = {4'h0, stat_r};
      default:         rdata_nxt = 8'h00;
    endcase
  end

  // Read data is held until the next read
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_r   <= 4'h0;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      stat_r   <= stat_nxt;
      rvalid_r <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt routing

  wire [3:0] enabled;
  wire       any_cause;
  wire       cause1;
  wire       cause2;
  wire       irq1;
  wire       irq2;

  // single source per pin or OR of enabled ones
  assign enabled   = stat_r & mask_r[`GPDM_EN_MSB:`GPDM_EN_LSB];
  assign any_cause = |enabled;
  assign cause1    = (fn1 == `GPDM_FN_IRQ_OR) ? any_cause :
                     stat_r[pin1_cfg_r[`GPDM_SRC1_MSB:`GPDM_SRC1_LSB]];
  assign cause2    = (fn2 == `GPDM_FN_IRQ_OR) ? any_cause :
                     stat_r[pin2_cfg_r[`GPDM_SRC2_MSB:`GPDM_SRC2_LSB]];

  gpdm_pulse #(
    .WIDTH_CYC  (PULSE_CYC),
    .PERIOD_CYC (TRAIN_CYC),
    .CW         (11)
  ) u_pulse1 (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .cause_in  (cause1),
    .train_in  (mask_r[`GPDM_TRAIN1_BIT]),
    .pulse_out (irq1)
  );

  gpdm_pulse #(
    .WIDTH_CYC  (PULSE_CYC),
    .PERIOD_CYC (TRAIN_CYC),
    .CW         (11)
  ) u_pulse2 (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .cause_in  (cause2),
    .train_in  (mask_r[`GPDM_TRAIN2_BIT]),
    .pulse_out (irq2)
  );

  //////////////////////////////////////////////////////////////////////////
  // Oversampling clock

  reg  [31:0] acc_r;
  reg  [31:0] step;
  reg         mic_clk_r;
  wire [32:0] acc_sum;
  wire        toggle;
  wire        rise_evt;
  wire        fall_evt;

  // phase step follows the programmed ratio; code 3 falls back to 128
  always @* begin
    case (osr)
      `GPDM_OSR_64: step = STEP_64_W;
      `GPDM_OSR_32: step = STEP_32_W;
      default:      step = STEP_128_W;
    endcase
  end

  assign acc_sum  = {1'b0, acc_r} + {1'b0, step};
  assign toggle   = acc_sum[32];
  assign rise_evt = toggle & ~mic_clk_r;
  assign fall_evt = toggle & mic_clk_r;

  // Phase accumulator keeps the average rate exact at the cost of edge jitter
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_r     <= 32'h0000_0000;
      mic_clk_r <= 1'b0;
    end else begin
      acc_r <= acc_sum[31:0];
      if (toggle) begin
        mic_clk_r <= ~mic_clk_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Microphone capture

  reg left_bit_r;
  reg left_vld_r;
  reg right_bit_r;
  reg right_vld_r;

  // Data is seen two cycles late through the synchroniser, well inside a half bit
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      left_bit_r  <= 1'b0;
      left_vld_r  <= 1'b0;
      right_bit_r <= 1'b0;
      right_vld_r <= 1'b0;
    end else begin
      left_vld_r  <= mic_en & rise_evt & edge_sel[`GPDM_EDGE_RISE_BIT];
      right_vld_r <= mic_en & fall_evt & edge_sel[`GPDM_EDGE_FALL_BIT];
      if (mic_en && rise_evt && edge_sel[`GPDM_EDGE_RISE_BIT]) begin
        left_bit_r <= pin_sync[1];
      end
      if (mic_en && fall_evt && edge_sel[`GPDM_EDGE_FALL_BIT]) begin
        right_bit_r <= pin_sync[1];
      end
    end
  end

  // one-bit stream straight to the decimation filter
  assign dmic_left_bit_out    = left_bit_r;
  assign dmic_left_valid_out  = left_vld_r;
  assign dmic_right_bit_out   = right_bit_r;
  assign dmic_right_valid_out = right_vld_r;
  // analog conversion off in mic mode
  assign adc_analog_off_out   = mic_en;

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers

  reg pin1_q_r;
  reg pin1_oe_n_r;
  reg pin2_q_r;
  reg pin2_oe_n_r;
  reg pin1_nxt;
  reg pin1_oe_n_nxt;
  reg pin2_nxt;
  reg pin2_oe_n_nxt;

  // two pins, each muxed by its function code
  always @* begin
    pin1_nxt      = 1'b0;
    pin1_oe_n_nxt = 1'b0;
    case (fn1)
      `GPDM_FN_OUT:    pin1_nxt = level_r[`GPDM_OUT1_BIT];
      `GPDM_FN_CLK:    pin1_nxt = mic_clk_r;
      `GPDM_FN_IRQ:    pin1_nxt = irq1;
      `GPDM_FN_IRQ_OR: pin1_nxt = irq1;
      default:         pin1_oe_n_nxt = 1'b1;
    endcase
    // mic mode takes pin one as clock
    if (mic_en) begin
      pin1_nxt      = mic_clk_r;
      pin1_oe_n_nxt = 1'b0;
    end
  end

  always @* begin
    pin2_nxt      = 1'b0;
    pin2_oe_n_nxt = 1'b0;
    case (fn2)
      `GPDM_FN_OUT:    pin2_nxt = level_r[`GPDM_OUT2_BIT];
      `GPDM_FN_CLK:    pin2_nxt = mic_clk_r;
      `GPDM_FN_IRQ:    pin2_nxt = irq2;
      `GPDM_FN_IRQ_OR: pin2_nxt = irq2;
      default:         pin2_oe_n_nxt = 1'b1;
    endcase
    // mic mode takes pin two as data input
    if (mic_en) begin
      pin2_nxt      = 1'b0;
      pin2_oe_n_nxt = 1'b1;
    end
  end

  // Registered pins avoid glitches from the mux
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin1_q_r    <= 1'b0;
      pin1_oe_n_r <= 1'b1;
      pin2_q_r    <= 1'b0;
      pin2_oe_n_r <= 1'b1;
    end else begin
      pin1_q_r    <= pin1_nxt;
      pin1_oe_n_r <= pin1_oe_n_nxt;
      pin2_q_r    <= pin2_nxt;
      pin2_oe_n_r <= pin2_oe_n_nxt;
    end
  end

  assign general_pin_one_out      = pin1_q_r;
  assign general_pin_one_oe_n_out = pin1_oe_n_r;
  assign general_pin_two_out      = pin2_q_r;
  assign general_pin_two_oe_n_out = pin2_oe_n_r;

endmodule

/* File: verif/gpdm_mic_model.sv */
`timescale 1ns/1ps
// Stereo microphone pair on the pin two data line, clocked by pin one
module gpdm_mic_model (
  input  wire  mclk_in,
  input  wire  nrst_in,
  input  wire  mic_clk_in,
  input  wire  gp_level_in,
  input  wire  mic_en_in,
  output wire  data_out,
  output logic left_exp_out,
  output logic right_exp_out
);
  logic       clk_q;
  logic [3:0] cnt;
  //////////////////////////////////////////////////////////////////
  // left after fall, right after rise
  // Bits change just after an edge so they stand a whole half period
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_q <= 1'b0;
      cnt <= 4'h0;
      left_exp_out <= 1'b0;
      right_exp_out <= 1'b1;
    end else begin
      clk_q <= mic_clk_in;
      if (mic_clk_in != clk_q)
        cnt <= cnt + 4'h1;
      if (!mic_clk_in && clk_q)
        left_exp_out <= cnt[1];
      if (mic_clk_in && !clk_q)
        right_exp_out <= ~cnt[2];
    end
  end
  // Outside mic mode the bench owns the line level
  assign data_out = mic_en_in ? (clk_q ? right_exp_out : left_exp_out) : gp_level_in;
endmodule

/* File: verif/gpdm_props.sv */
`timescale 1ns/1ps
`include "gpdm_map.vh"
module gpdm_props (
  input wire       mclk_in,
  input wire       nrst_in,
  input wire [7:0] reg_addr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  input wire       evt_jack_in,
  input wire       evt_button_in,
  input wire       evt_short_in,
  input wire       evt_auto_gain_loop_in,
  input wire       general_pin_one_out,
  input wire       general_pin_one_oe_n_out,
  input wire       general_pin_two_oe_n_out,
  input wire       dmic_left_valid_out,
  input wire       dmic_right_valid_out,
  input wire       adc_analog_off_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire any_evt = evt_jack_in | evt_button_in | evt_short_in | evt_auto_gain_loop_in;
  wire a_map = reg_addr_in inside {`GPDM_REG_PIN2, `GPDM_REG_DMIC, `GPDM_REG_PIN1,
                                   `GPDM_REG_LEVEL, `GPDM_REG_MASK, `GPDM_REG_STAT};
  wire p1 = general_pin_one_out;
  wire off = adc_analog_off_out;
  //////////////////////////////////////////////////////////////////
  sequence s_stat_rd;
    reg_rd_in && reg_addr_in == `GPDM_REG_STAT && !any_evt;
  endsequence
  sequence s_hi_phase;
    (p1 || !off) [*6];
  endsequence
  property p_rvalid; reg_rd_in |=> reg_rvalid_out; endproperty
  property p_no_rvalid; !reg_rd_in |=> !reg_rvalid_out; endproperty
  property p_unmapped; reg_rd_in && !a_map |=> reg_rdata_out == 8'h00; endproperty
  property p_rdata_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  property p_stat_clear;
    s_stat_rd ##1 (!any_evt && !reg_rd_in) ##1 s_stat_rd |=> reg_rdata_out == 8'h00;
  endproperty
  property p_mic_pins;
    off && $past(off) && $past(off, 2) |-> !general_pin_one_oe_n_out && general_pin_two_oe_n_out;
  endproperty
  // The pin follows the internal clock one cycle after the capture strobe
  property p_left_edge; dmic_left_valid_out && off |=> $rose(p1); endproperty
  property p_right_edge; dmic_right_valid_out && off |=> $fell(p1); endproperty
  property p_mic_clk; $rose(p1) && off |-> ##1 s_hi_phase ##[1:28] (!p1 || !off); endproperty
  property p_quiet;
    !off && $past(!off) && $past(!off, 2) |-> !dmic_left_valid_out && !dmic_right_valid_out;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read without valid");
  a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");
  a_mic_pins: assert property (p_mic_pins) else $error("mic pin roles wrong");
  a_left_edge: assert property (p_left_edge) else $error("left off rising");
  a_right_edge: assert property (p_right_edge) else $error("right off falling");
  a_mic_clk: assert property (p_mic_clk) else $error("mic clock phase length");
  a_quiet: assert property (p_quiet) else $error("mic data outside mic mode");
endmodule
bind gpdm_top gpdm_props u_props (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .evt_jack_in(evt_jack_in), .evt_button_in(evt_button_in),
  .evt_short_in(evt_short_in), .evt_auto_gain_loop_in(evt_auto_gain_loop_in),
  .general_pin_one_out(general_pin_one_out),
  .general_pin_one_oe_n_out(general_pin_one_oe_n_out),
  .general_pin_two_oe_n_out(general_pin_two_oe_n_out),
  .dmic_left_valid_out(dmic_left_valid_out), .dmic_right_valid_out(dmic_right_valid_out),
  .adc_analog_off_out(adc_analog_off_out));

/* File: verif/gpdm_top_bench.sv */
`timescale 1ns/1ps
`include "gpdm_map.vh"
module gpdm_top_bench;
  logic       mclk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] evt = 4'h0;
  logic       p1_drv = 1'b1;
  logic       p2_lvl = 1'b0;
  logic       mic_on = 1'b0;
  logic       bit_on = 1'b0;
  logic [7:0] q;
  wire  [7:0] rdata;
  wire        rvalid, p1o, p1e, p2o, p2e, lb, lv, rb, rv, aoff, mdat, lexp, rexp;
  wire        p1w = p1e ? p1_drv : p1o;
  wire        p2w = p2e ? mdat : p2o;
  int         bad_count = 0;
  int         num_checks = 0;
  int         nl, nr, n, h;
  int         ev[3] = '{153, 76, 38};
  gpdm_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .evt_jack_in(evt[0]), .evt_button_in(evt[1]),
    .evt_short_in(evt[2]), .evt_auto_gain_loop_in(evt[3]), .general_pin_one_in(p1w),
    .general_pin_one_out(p1o), .general_pin_one_oe_n_out(p1e), .general_pin_two_in(p2w),
    .general_pin_two_out(p2o), .general_pin_two_oe_n_out(p2e), .dmic_left_bit_out(lb),
    .dmic_left_valid_out(lv), .dmic_right_bit_out(rb), .dmic_right_valid_out(rv),
    .adc_analog_off_out(aoff));
  gpdm_mic_model u_mic (.mclk_in(mclk_in), .nrst_in(nrst_in), .mic_clk_in(p1w),
    .gp_level_in(p2_lvl), .mic_en_in(mic_on), .data_out(mdat), .left_exp_out(lexp),
    .right_exp_out(rexp));
  //////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs about 210 us
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  initial begin
    #600us;
    bad_count++;
    tally_and_finish();
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge mclk_in);
    wr = 1'b0;
  endtask
  // Read strobe one cycle; valid and data land on the next edge
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_in);
    addr = a;
    rd = 1'b1;
    @(negedge mclk_in);
    rd = 1'b0;
    chk(rvalid, 8'h01, "read valid");
    chk(rdata, e, "read data");
  endtask
  task pulse_evt(input int s);
    @(negedge mclk_in);
    evt[s] = 1'b1;
    @(negedge mclk_in);
    evt[s] = 1'b0;
  endtask
  // Counts rising edges and high cycles of one pin over a window
  task cnt_pin(input bit sel, input int ncyc);
    logic pv;
    logic cur;
    pv = sel ? p2w : p1w;
    n = 0;
    h = 0;
    repeat (ncyc) begin
      @(negedge mclk_in);
      cur = sel ? p2w : p1w;
      n += int'(cur && !pv);
      h += int'(cur);
      pv = cur;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Captured bits are checked against the microphone's output while bit_on is set
  always @(negedge mclk_in) begin
    if (lv === 1'b1 && bit_on) begin
      nl++;
      chk(lb, lexp, "left bit");
    end
    if (rv === 1'b1 && bit_on) begin
      nr++;
      chk(rb, rexp, "right bit");
    end
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk_in);
    nrst_in = 1'b1;
    foreach (ev[i]) rd_chk(8'h19 + 8'(i * 82), 8'h00);
    // Pin one is pulled high while released, so its level bit reads one
    for (int a = 8'h70; a < 8'h74; a++) rd_chk(8'(a), (a == 8'h71) ? 8'h10 : 8'h00);
    wr_reg(8'h55, 8'hff);
    rd_chk(8'h55, 8'h00);
    chk({p1e, p2e, aoff}, 8'h06, "reset pins");
    $display("test reset done");
    wr_reg(`GPDM_REG_PIN1, 8'h01);
    wr_reg(`GPDM_REG_PIN2, 8'h01);
    wr_reg(`GPDM_REG_LEVEL, 8'h01);
    repeat (2) @(negedge mclk_in);
    chk({p1e, p2e, p1o, p2o}, 8'h02, "driven levels");
    rd_chk(`GPDM_REG_LEVEL, 8'h11);
    wr_reg(`GPDM_REG_PIN1, 8'h00);
    wr_reg(`GPDM_REG_PIN2, 8'h00);
    repeat (3) @(negedge mclk_in);
    p1_drv = 1'b0;
    p2_lvl = 1'b1;
    rd_chk(`GPDM_REG_LEVEL, 8'h11);
    rd_chk(`GPDM_REG_LEVEL, 8'h21);
    $display("test pins done");
    for (int s = 0; s < 4; s++) begin
      wr_reg(`GPDM_REG_PIN1, 8'(s * 16 + 3));
      pulse_evt(s);
      cnt_pin(1'b0, 300);
      chk(8'(n), 8'h01, "single pulse");
      chk(8'(h), 8'h64, "pulse width");
      rd_chk(`GPDM_REG_STAT, 8'(1 << s));
      rd_chk(`GPDM_REG_STAT, 8'h00);
    end
    wr_reg(`GPDM_REG_MASK, 8'h21);
    wr_reg(`GPDM_REG_PIN2, 8'h04);
    pulse_evt(3);
    cnt_pin(1'b1, 1500);
    chk(8'(n), 8'h00, "masked source");
    rd_chk(`GPDM_REG_STAT, 8'h08);
    pulse_evt(0);
    cnt_pin(1'b1, 3000);
    chk(8'(n), 8'h03, "pulse train");
    rd_chk(`GPDM_REG_STAT, 8'h01);
    cnt_pin(1'b1, 1000);
    cnt_pin(1'b1, 2000);
    chk(8'(n), 8'h00, "train stopped");
    $display("test interrupts done");
    mic_on = 1'b1;
    wr_reg(`GPDM_REG_DMIC, 8'h30);
    // First captures still carry the level from before pin two was released
    repeat (4) @(negedge mclk_in);
    bit_on = 1'b1;
    foreach (ev[o]) begin
      wr_reg(`GPDM_REG_PIN2, 8'(o * 16));
      cnt_pin(1'b0, 2500);
      chk(8'(n >= ev[o] - 1 && n <= ev[o] + 2), 8'h01, "mic clock rate");
    end
    chk({aoff, p1e, p2e}, 8'h05, "mic pin roles");
    for (int e = 1; e < 4; e++) begin
      wr_reg(`GPDM_REG_DMIC, 8'(e * 16));
      repeat (4) @(negedge mclk_in);
      nl = 0;
      nr = 0;
      repeat (600) @(negedge mclk_in);
      chk({nr > 0, nl > 0}, 8'(e), "capture edges");
    end
    wr_reg(`GPDM_REG_DMIC, 8'h00);
    mic_on = 1'b0;
    wr_reg(`GPDM_REG_PIN1, 8'h02);
    cnt_pin(1'b0, 2500);
    chk(8'(n >= ev[2] - 1 && n <= ev[2] + 2), 8'h01, "clock function");
    chk(aoff, 8'h00, "analog back");
    $display("test mic done");
    tally_and_finish();
  end
endmodule
